// file: dv/bmd_branch_core_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module bmd_branch_core_test;
  import bmd_pkg::*;

  typedef struct packed {
    logic chk;
    logic [ADR_W-1:0] adr;
    logic [DATA_W-1:0] val;
  } bmd_note_s;

  logic clk_i;
  logic rst_i;
  bmd_wb_req_s wb_req_i;
  bmd_wb_rsp_s wb_rsp_o;
  logic [PC_W-1:0] pc_o;
  logic [ACC_W-1:0] acc_o;
  logic carry_o;
  logic zero_o;
  bmd_note_s notes[$];
  bmd_note_s cur;
  int miscompares = 0;
  int checked = 0;
  logic [15:0] rnd = 16'hf030;
  logic [4:0] ops [9] = '{OP_JB0, OP_JB1, OP_JB2, OP_JB3, OP_JNZ, OP_JNC, OP_JZ, OP_JC, OP_JMP};

  bmd_branch_core uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o),
    .pc_o(pc_o),
    .acc_o(acc_o),
    .carry_o(carry_o),
    .zero_o(zero_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic taken(logic [4:0] op, logic [3:0] a, logic c);
    case (op)
      OP_JB0: return a[0];
      OP_JB1: return a[1];
      OP_JB2: return a[2];
      OP_JB3: return a[3];
      OP_JNZ: return a != 4'h0;
      OP_JNC: return ~c;
      OP_JZ: return a == 4'h0;
      OP_JC: return c;
      default: return 1'b1;
    endcase
  endfunction

  task automatic results();
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  // A lost ack is left to the watchdog
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] d);
    notes.push_back('{chk: ~w, adr: a, val: d});
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: w ? d : '0};
    do
    begin
      @(posedge clk_i);
    end
    while (wb_rsp_o.ack !== 1'b1);
    wb_req_i <= '0;
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus(1'b0, a, e);
  endtask

  task automatic exec(input logic [INSTR_W-1:0] i);
    wr(OFS_INSTR, 32'(i));
  endtask

  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  // Port outputs are checked beside the register copy they mirror
  always @(posedge clk_i)
  begin
    if (wb_rsp_o.ack === 1'b1)
    begin
      if (notes.size() == 0)
        miscompares++;
      else
      begin
        cur = notes.pop_front();
        if (cur.chk)
        begin
          `CHK(wb_rsp_o.dat, cur.val)
          case (cur.adr)
            OFS_PC: `CHK(32'(pc_o), cur.val)
            OFS_ACC: `CHK(32'(acc_o), cur.val)
            OFS_FLAGS: `CHK({30'h0, zero_o, carry_o}, cur.val)
            default: ;
          endcase
        end
      end
    end
  end

  initial
  begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    results();
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    logic [3:0] a;
    logic [3:0] nib;
    logic c;
    logic tk;
    logic [10:0] tgt;
    logic [10:0] pc0;
    logic [10:0] ep;
    logic [6:0] ad;
    rst_i = 1'b1;
    wb_req_i = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_PC, 32'h0);
    rd(OFS_ACC, 32'h0);
    rd(OFS_FLAGS, 32'h0);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
    // Every accumulator value and carry for every branch; 7ff forces wrap when the branch is not taken
    foreach (ops[k])
    begin
      for (int v = 0; v < 32; v++)
      begin
        a = v[3:0];
        c = v[4];
        rnd = nxt(rnd);
        tgt = rnd[10:0];
        rnd = nxt(rnd);
        pc0 = (a == 4'hf) ? 11'h7ff : rnd[10:0];
        wr(OFS_ACC, 32'(a));
        wr(OFS_FLAGS, 32'(c));
        wr(OFS_PC, 32'(pc0));
        exec({ops[k], tgt});
        tk = taken(ops[k], a, c);
        ep = tk ? tgt : pc0 + 11'h1;
        rd(OFS_PC, 32'(ep));
        rd(OFS_STATUS, 32'(tk));
        rd(OFS_FLAGS, 32'(c));
      end
    end
    // Flags preset opposite to the expected result so a missed update shows
    for (int i = 0; i < 8; i++)
    begin
      rnd = nxt(rnd);
      ad = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : rnd[6:0];
      nib = (i == 2) ? 4'h0 : rnd[10:7];
      pc0 = {rnd[15:11], rnd[5:0]};
      wr(RAM_BASE + {3'h0, ad, 2'b00}, 32'(nib));
      wr(OFS_ACC, 32'(~nib));
      wr(OFS_FLAGS, {30'h0, nib != 4'h0, ~nib[0]});
      wr(OFS_PC, 32'(pc0));
      exec({OP_LDA, ad});
      rd(OFS_ACC, 32'(nib));
      rd(OFS_FLAGS, {30'h0, nib == 4'h0, ~nib[0]});
      exec({OP_LDC, ad});
      rd(OFS_FLAGS, {30'h0, nib == 4'h0, nib[0]});
      rd(OFS_ACC, 32'(nib));
      ep = pc0 + 11'h2;
      rd(OFS_PC, 32'(ep));
    end
    // Unknown code: only the sticky flag and the last word change
    wr(OFS_PC, 32'(pc0));
    exec(16'h0000);
    rd(OFS_INSTR, 32'h0);
    rd(OFS_PC, 32'(pc0));
    rd(OFS_STATUS, 32'h2);
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h0);
    results();
  end

endmodule // bmd_branch_core_test

// file: rtl/bmd_branch_core.sv
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - Prefix 10100: jump if accumulator bit two
// - Prefix 10110: jump if accumulator bit three
// - Jump on carry set, else increment
// - Prefix 01110: unconditional jump to target
// - Prefix 11010: jump when carry clear
// - Prefix 11000: jump when accumulator nonzero
// - Prefix 11100: jump when accumulator zero
// - Load accumulator from addressed RAM nibble
// - Carry takes RAM bit zero only
// - Prefixes 10000/10010 test bits zero, one
module bmd_branch_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input bmd_pkg::bmd_wb_req_s wb_req_i,
  output bmd_pkg::bmd_wb_rsp_s wb_rsp_o,
  output logic [bmd_pkg::PC_W-1:0] pc_o,
  output logic [bmd_pkg::ACC_W-1:0] acc_o,
  output logic carry_o,
  output logic zero_o
);
  import bmd_pkg::*;

  bmd_state_s st_reg;
  bmd_state_s st_next;

  logic bus_live;
  logic commit;
  logic wr;
  logic exec_go;
  logic instr_wr_pending;
  logic ram_hit;
  logic ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [ACC_W-1:0] ram_q;
  logic [INSTR_W-1:0] instr;
  logic [4:0] op5;
  logic [8:0] op9;
  logic [PC_W-1:0] tgt;
  logic [PC_W-1:0] pc_inc;
  logic is_jump;
  logic cond;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign bus_live = wb_req_i.cyc && wb_req_i.stb;
  assign commit = bus_live && (st_reg.phase == PH_ACCESS);
  assign wr = commit && wb_req_i.we;
  assign ram_hit = wb_req_i.adr[ADR_W-1:RAM_IDX_MSB+1] == RAM_BASE[ADR_W-1:RAM_IDX_MSB+1];
  assign instr = wb_req_i.dat[INSTR_W-1:0];
  // Only a full 16-bit write launches an instruction
  assign exec_go = wr && (wb_req_i.adr == OFS_INSTR) && (wb_req_i.sel[1:0] == 2'b11);
  assign instr_wr_pending = (st_reg.phase == PH_ACCESS) && wb_req_i.we
    && (wb_req_i.adr == OFS_INSTR);
  assign op5 = instr[15:11];
  assign op9 = instr[15:7];
  assign tgt = instr[PC_W-1:0];
  assign pc_inc = st_reg.pc + 11'h001;

  // Operand fetch borrows the RAM port during the instruction write
  assign ram_addr = instr_wr_pending ? instr[RAM_AW-1:0]
    : wb_req_i.adr[RAM_IDX_MSB:RAM_IDX_LSB];
  assign ram_we = wr && ram_hit && wb_req_i.sel[0];

  bmd_nibble_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(RAM_AW),
    .DW(ACC_W)
  ) u_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(wb_req_i.dat[ACC_W-1:0]),
    .rdata_o(ram_q)
  );

  // ----------------------------------------
  // Branch condition decode
  // ----------------------------------------
  always_comb
  begin
    is_jump = 1'b1;
    cond = 1'b0;
    case (op5)
      OP_JB0: cond = st_reg.acc[0];
      OP_JB1: cond = st_reg.acc[1];
      OP_JB2: cond = st_reg.acc[2];
      OP_JB3: cond = st_reg.acc[3];
      OP_JC: cond = st_reg.carry;
      OP_JNC: cond = !st_reg.carry;
      OP_JNZ: cond = (st_reg.acc != 4'h0);
      OP_JZ: cond = (st_reg.acc == 4'h0);
      OP_JMP: cond = 1'b1;
      default: is_jump = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [DATA_W-1:0] rd_val;
    rd_val = '0;
    st_next = st_reg;

    // Bus phase sequencing; ack lasts exactly one cycle
    case (st_reg.phase)
      PH_IDLE:
      begin
        st_next.ack = 1'b0;
        if (bus_live)
        begin
          st_next.phase = PH_ACCESS;
        end
      end
      PH_ACCESS:
      begin
        st_next.phase = PH_ACK;
        st_next.ack = 1'b1;
      end
      PH_ACK:
      begin
        st_next.phase = PH_IDLE;
        st_next.ack = 1'b0;
      end
      default:
      begin
        st_next.phase = PH_IDLE;
        st_next.ack = 1'b0;
      end
    endcase

    // Read data; unmapped addresses read as zero
    if (ram_hit)
    begin
      rd_val = DATA_W'(ram_q);
    end
    else
    begin
      case (wb_req_i.adr)
        OFS_INSTR: rd_val = DATA_W'(st_reg.last_instr);
        OFS_PC: rd_val = DATA_W'(st_reg.pc);
        OFS_ACC: rd_val = DATA_W'(st_reg.acc);
        OFS_FLAGS:
        begin
          rd_val[FLAG_CARRY_BIT] = st_reg.carry;
          rd_val[FLAG_ZERO_BIT] = st_reg.zero;
        end
        OFS_STATUS:
        begin
          rd_val[STAT_TAKEN_BIT] = st_reg.taken;
          rd_val[STAT_BAD_BIT] = st_reg.bad;
          rd_val[STAT_PEND_BIT] = (st_reg.load != LD_NONE);
        end
        default: rd_val = '0;
      endcase
    end
    if (commit && !wb_req_i.we)
    begin
      st_next.dat = rd_val;
    end

    // Direct register writes from software
    if (wr && wb_req_i.adr == OFS_PC)
    begin
      if (wb_req_i.sel[0])
      begin
        st_next.pc[7:0] = wb_req_i.dat[7:0];
      end
      if (wb_req_i.sel[1])
      begin
        st_next.pc[PC_W-1:8] = wb_req_i.dat[PC_W-1:8];
      end
    end
    if (wr && wb_req_i.sel[0] && wb_req_i.adr == OFS_ACC)
    begin
      st_next.acc = wb_req_i.dat[ACC_W-1:0];
    end
    if (wr && wb_req_i.sel[0] && wb_req_i.adr == OFS_FLAGS)
    begin
      st_next.carry = wb_req_i.dat[FLAG_CARRY_BIT];
      st_next.zero = wb_req_i.dat[FLAG_ZERO_BIT];
    end
    if (wr && wb_req_i.sel[0] && wb_req_i.adr == OFS_STATUS && wb_req_i.dat[STAT_BAD_BIT])
    begin
      st_next.bad = 1'b0;
    end

    // Pending RAM operand arrives one cycle after the launch
    case (st_reg.load)
      LD_ACC:
      begin
        st_next.acc = ram_q;
        st_next.zero = (ram_q == 4'h0);
      end
      LD_CARRY:
      begin
        st_next.carry = ram_q[0];
      end
      default:
      begin
      end
    endcase
    st_next.load = LD_NONE;

    // Instruction execution; placed last so the flag set wins over a clear
    if (exec_go)
    begin
      st_next.last_instr = instr;
      if (is_jump)
      begin
        st_next.pc = cond ? tgt : pc_inc;
        st_next.taken = cond;
      end
      else if (op9 == OP_LDA)
      begin
        st_next.load = LD_ACC;
        st_next.pc = pc_inc;
        st_next.taken = 1'b0;
      end
      else if (op9 == OP_LDC)
      begin
        st_next.load = LD_CARRY;
        st_next.pc = pc_inc;
        st_next.taken = 1'b0;
      end
      else
      begin
        // Unknown code leaves the core untouched except the sticky flag and last_instr
        st_next.bad = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= ST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_rsp_o.ack = st_reg.ack;
  assign wb_rsp_o.dat = st_reg.dat;
  assign pc_o = st_reg.pc;
  assign acc_o = st_reg.acc;
  assign carry_o = st_reg.carry;
  assign zero_o = st_reg.zero;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_exec(logic [4:0] op);
    exec_go && (op5 == op);
  endsequence

  sequence s_load(logic [8:0] op);
    exec_go && (op9 == op);
  endsequence

  property p_bit_two;
    s_exec(OP_JB2) |=> pc_o == ((($past(acc_o) & 4'h4) != 4'h0) ? $past(tgt) : $past(pc_inc));
  endproperty
  a_bit_two: assert property (p_bit_two) else $error("bit two jump wrong pc");

  property p_bit_three;
    s_exec(OP_JB3) |=> pc_o == ((($past(acc_o) & 4'h8) != 4'h0) ? $past(tgt) : $past(pc_inc));
  endproperty
  a_bit_three: assert property (p_bit_three) else $error("bit three jump wrong pc");

  property p_carry_set;
    s_exec(OP_JC) |=> pc_o == ($past(carry_o) ? $past(tgt) : $past(pc_inc));
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry jump wrong pc");

  property p_absolute;
    s_exec(OP_JMP) |=> (pc_o == $past(tgt)) && st_reg.taken;
  endproperty
  a_absolute: assert property (p_absolute) else $error("absolute jump missed");

  property p_carry_clear;
    s_exec(OP_JNC) |=> pc_o == ($past(carry_o) ? $past(pc_inc) : $past(tgt));
  endproperty
  a_carry_clear: assert property (p_carry_clear) else $error("no-carry jump wrong");

  property p_nonzero;
    s_exec(OP_JNZ) |=> pc_o == (($past(acc_o) != 4'h0) ? $past(tgt) : $past(pc_inc));
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("nonzero jump wrong pc");

  property p_zero;
    s_exec(OP_JZ) |=> pc_o == (($past(acc_o) == 4'h0) ? $past(tgt) : $past(pc_inc));
  endproperty
  a_zero: assert property (p_zero) else $error("zero jump wrong pc");

  property p_load_acc;
    s_load(OP_LDA) |-> ##2 (acc_o == $past(ram_q)) && (zero_o == ($past(ram_q) == 4'h0));
  endproperty
  a_load_acc: assert property (p_load_acc) else $error("accumulator load wrong");

  property p_load_carry;
    s_load(OP_LDC) |-> ##2 (carry_o == $past(ram_q[0])) && $stable(acc_o) && $stable(zero_o);
  endproperty
  a_load_carry: assert property (p_load_carry) else $error("carry load wrong");

  // Opcode bit 1 tells the bit-one test from the bit-zero test
  property p_low_bits;
    (s_exec(OP_JB0) or s_exec(OP_JB1)) |=>
      (pc_o == ($past(op5[1] ? acc_o[1] : acc_o[0]) ? $past(tgt) : $past(pc_inc)))
      && (st_reg.taken == $past(op5[1] ? acc_o[1] : acc_o[0]));
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low bit jump wrong");

  property p_single_cycle;
    (exec_go && is_jump) |=> wb_rsp_o.ack && (st_reg.load == LD_NONE) ##1 $stable(pc_o);
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("branch not one cycle");

endmodule // bmd_branch_core

// file: rtl/bmd_nibble_ram.sv
`timescale 1ns/100ps
module bmd_nibble_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter int DW = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  import bmd_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] cells;
    logic [DW-1:0] q;
  } bmd_ram_s;

  bmd_ram_s st_reg;
  bmd_ram_s st_next;

  // Read-before-write: q shows the old nibble on a write
  always_comb
  begin
    st_next = st_reg;
    st_next.q = st_reg.cells[addr_i];
    if (we_i)
    begin
      st_next.cells[addr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.q;

endmodule // bmd_nibble_ram

// file: shared/bmd_pkg.sv
package bmd_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int SEL_W = DATA_W / 8;
  localparam int ADR_W = 12;
  localparam int INSTR_W = 16;
  localparam int PC_W = 11;
  localparam int ACC_W = 4;
  localparam int RAM_AW = 7;
  localparam int RAM_DEPTH = 128;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [ADR_W-1:0] OFS_INSTR = 12'h000;
  localparam logic [ADR_W-1:0] OFS_PC = 12'h004;
  localparam logic [ADR_W-1:0] OFS_ACC = 12'h008;
  localparam logic [ADR_W-1:0] OFS_FLAGS = 12'h00c;
  localparam logic [ADR_W-1:0] OFS_STATUS = 12'h010;
  localparam logic [ADR_W-1:0] RAM_BASE = 12'h200;
  localparam int RAM_IDX_LSB = 2;
  localparam int RAM_IDX_MSB = 8;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_ZERO_BIT = 1;
  localparam int STAT_TAKEN_BIT = 0;
  localparam int STAT_BAD_BIT = 1;
  localparam int STAT_PEND_BIT = 2;

  // ----------------------------------------
  // Opcode prefixes
  // ----------------------------------------
  localparam logic [4:0] OP_JB0 = 5'h10;
  localparam logic [4:0] OP_JB1 = 5'h12;
  localparam logic [4:0] OP_JB2 = 5'h14;
  localparam logic [4:0] OP_JB3 = 5'h16;
  localparam logic [4:0] OP_JNZ = 5'h18;
  localparam logic [4:0] OP_JNC = 5'h1a;
  localparam logic [4:0] OP_JZ = 5'h1c;
  localparam logic [4:0] OP_JC = 5'h1e;
  localparam logic [4:0] OP_JMP = 5'h0e;
  localparam logic [8:0] OP_LDA = 9'h09d;
  localparam logic [8:0] OP_LDC = 9'h0b0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [ACC_W-1:0] ACC_RST = 4'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] dat;
  } bmd_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] dat;
  } bmd_wb_rsp_s;

  typedef enum logic [1:0] {PH_IDLE, PH_ACCESS, PH_ACK} bmd_phase_e;
  typedef enum logic [1:0] {LD_NONE, LD_ACC, LD_CARRY} bmd_load_e;

  typedef struct packed {
    bmd_phase_e phase;
    bmd_load_e load;
    logic ack;
    logic [DATA_W-1:0] dat;
    logic [INSTR_W-1:0] last_instr;
    logic [PC_W-1:0] pc;
    logic [ACC_W-1:0] acc;
    logic carry;
    logic zero;
    logic taken;
    logic bad;
  } bmd_state_s;

  localparam bmd_state_s ST_RST = '{phase: PH_IDLE, load: LD_NONE, ack: 1'b0,
    dat: '0, last_instr: '0, pc: PC_RST, acc: ACC_RST, carry: 1'b0,
    zero: 1'b0, taken: 1'b0, bad: 1'b0};

endpackage
